// ### rtl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // first stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // reset to the idle level of each pin so no false edge appears
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= '{stage1: reset_val, stage2: reset_val};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule : pin_sync

// ### rtl/result_buffer.sv
// two-entry buffer between the sar and the output latch
// assumes one clock; in_ready stalls the writer when both entries hold
`timescale 1ns/1ns
module result_buffer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [11:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [11:0] out_data
);

  typedef struct packed {
    logic [1:0][11:0] mem;
    logic             rd_ptr;
    logic             wr_ptr;
    logic [1:0]       count;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic       push;
  logic       pop;

  always_comb begin
    push       = in_valid && (state_reg.count != 2'h2);
    pop        = out_ready && (state_reg.count != 2'h0);
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr                = ~state_reg.wr_ptr;
    end
    if (pop) begin
      state_next.rd_ptr = ~state_reg.rd_ptr;
    end
    case ({push, pop})
      2'b10:   state_next.count = state_reg.count + 2'h1;
      2'b01:   state_next.count = state_reg.count - 2'h1;
      default: state_next.count = state_reg.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_ready  = (state_reg.count != 2'h2);
  assign out_valid = (state_reg.count != 2'h0);
  assign out_data  = state_reg.mem[state_reg.rd_ptr];

endmodule : result_buffer

// ### rtl/sar_adc_control.sv
// control logic of a 12-bit successive-approximation converter
// assumes host pins and comparator are asynchronous to clk; the
// analog dac follows trial_code and answers on cmp_in
//
// Summary of operation
// - read falling with select and upper byte select low starts conversion
// - upper byte select high blocks any conversion start
// - with chip select high, read and upper byte select are ignored
// - data pins driven only while select and read are both low
// - busy low for the whole conversion, high when result is ready
// - upper byte select low gives the full word, msb on top pin
// - upper byte select high puts bits 11..8 on the top four and the low four pins, next four low
// - conversion start clears the sar and enables data drivers
// - further start conditions ignored until the conversion completes
// - one bit decided per step, msb first, from the comparator
// - final sar word copied into the latch that serves reads
// - unipolar code is natural binary, one lsb is full scale/4096
`timescale 1ns/1ns
`include "sar_adc_defines.svh"
module sar_adc_control (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             upper_byte_select,
  input  wire logic             cmp_in,
  output logic                  busy_n,
  output logic [`RES_W-1:0]     trial_code,
  output logic                  sample_track,
  output sar_adc_pkg::data_pins_t data_pins
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [`RES_W-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = `RES_W'(12'h001 << idx);
  endfunction : bit_mask

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sar_adc_pkg::conv_state_t    st;
    logic [`RES_W-1:0]           sar;
    logic [3:0]                  bit_idx;
    logic [`STEP_CNT_W-1:0]      step_cnt;
    logic                        rd_prev;
    logic [`RES_W-1:0]           latch;
    logic                        busy_n;
    logic                        sample_track;
    sar_adc_pkg::data_pins_t     pins;
  } core_state_t;

  core_state_t          state_reg;
  core_state_t          state_next;
  sar_adc_pkg::pins_t   pin_s;
  logic                 rd_active;
  logic                 rd_fall;
  logic                 start;
  logic                 step_end;
  logic                 buf_in_ready;
  logic                 buf_out_valid;
  logic                 buf_out_ready;
  logic [`RES_W-1:0]    buf_out_data;
  logic                 push_valid;

  localparam logic [`STEP_CNT_W-1:0] STEP_LAST =
    `STEP_CNT_W'(`STEP_CYC - 1);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .clk       (clk),
    .nrst      (nrst),
    .async_in  ({cs_n, rd_n, upper_byte_select, cmp_in}),
    .reset_val (`PIN_IDLE),
    .sync_out  (pin_s)
  );

  // ****************************************************************
  // result buffer
  // ****************************************************************
  // holds the word still when a second result arrives during a read,
  // so a stalled latch update never drops a conversion
  result_buffer u_result_buffer (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push_valid),
    .in_ready  (buf_in_ready),
    .in_data   (state_reg.sar),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ****************************************************************
  // decode of host strobes
  // ****************************************************************
  always_comb begin
    rd_active  = !pin_s.cs_n && !pin_s.rd_n;
    rd_fall    = state_reg.rd_prev && !pin_s.rd_n;
    start      = (state_reg.st == sar_adc_pkg::ST_IDLE) && rd_fall &&
                 !pin_s.cs_n && !pin_s.upper_byte_select;
    step_end   = (state_reg.st == sar_adc_pkg::ST_STEP) &&
                 (state_reg.step_cnt == STEP_LAST);
    push_valid = (state_reg.st == sar_adc_pkg::ST_PUSH);
    // hold the latch during an upper byte read so both bytes match
    buf_out_ready = !(rd_active && pin_s.upper_byte_select);
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_next         = state_reg;
    state_next.rd_prev = pin_s.rd_n;
    case (state_reg.st)
      sar_adc_pkg::ST_IDLE: begin
        if (start) begin
          state_next.st       = sar_adc_pkg::ST_STEP;
          state_next.sar      = `SAR_START;
          state_next.bit_idx  = `MSB_IDX;
          state_next.step_cnt = '0;
        end
      end
      sar_adc_pkg::ST_STEP: begin
        state_next.step_cnt = state_reg.step_cnt + `STEP_CNT_W'(1);
        if (step_end) begin
          state_next.step_cnt = '0;
          if (!pin_s.cmp_hi) begin
            state_next.sar = state_reg.sar &
                             ~bit_mask(state_reg.bit_idx);
          end
          if (state_reg.bit_idx == 4'h0) begin
            state_next.st = sar_adc_pkg::ST_PUSH;
          end else begin
            state_next.bit_idx = state_reg.bit_idx - 4'h1;
            state_next.sar     = state_next.sar |
                                 bit_mask(state_reg.bit_idx - 4'h1);
          end
        end
      end
      sar_adc_pkg::ST_PUSH: begin
        if (buf_in_ready) begin
          state_next.st = sar_adc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next.st = sar_adc_pkg::ST_IDLE;
      end
    endcase

    // busy follows the sequencer; stays low while the buffer stalls
    state_next.busy_n = (state_next.st == sar_adc_pkg::ST_IDLE);
    state_next.sample_track = state_next.busy_n;

    if (buf_out_valid && buf_out_ready) begin
      state_next.latch = buf_out_data;
    end

    // output pins from the latch; a start read sees the old word
    state_next.pins.upper_data_oe      = rd_active;
    state_next.pins.shared_low_data_oe = rd_active;
    state_next.pins.upper_data_outputs = '0;
    state_next.pins.shared_low_data_outputs = '0;
    if (rd_active) begin
      if (pin_s.upper_byte_select) begin
        state_next.pins.upper_data_outputs =
          {state_reg.latch[11:8], 4'h0};
        state_next.pins.shared_low_data_outputs =
          state_reg.latch[11:8];
      end else begin
        state_next.pins.upper_data_outputs =
          state_reg.latch[11:4];
        state_next.pins.shared_low_data_outputs =
          state_reg.latch[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg              <= '0;
      state_reg.st           <= sar_adc_pkg::ST_IDLE;
      state_reg.sar          <= `SAR_RESET;
      state_reg.latch        <= `LATCH_RESET;
      state_reg.rd_prev      <= 1'b1;
      state_reg.busy_n       <= 1'b1;
      state_reg.sample_track <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy_n       = state_reg.busy_n;
  assign trial_code   = state_reg.sar;
  assign sample_track = state_reg.sample_track;
  assign data_pins    = state_reg.pins;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_start_busy;
    @(posedge clk) disable iff (!nrst)
      start |=> !busy_n ##1 !busy_n;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("accepted start did not pull busy low");

  property p_no_start_upper;
    @(posedge clk) disable iff (!nrst)
      (state_reg.st == sar_adc_pkg::ST_IDLE) && pin_s.upper_byte_select
      |=> busy_n;
  endproperty
  a_no_start_upper: assert property (p_no_start_upper)
    else $error("conversion began with upper byte select high");

  property p_cs_ignore;
    @(posedge clk) disable iff (!nrst)
      (state_reg.st == sar_adc_pkg::ST_IDLE) && pin_s.cs_n
      |=> busy_n && !data_pins.upper_data_oe;
  endproperty
  a_cs_ignore: assert property (p_cs_ignore)
    else $error("strobes acted while chip select high");

  property p_oe;
    @(posedge clk) disable iff (!nrst)
      ##1 (data_pins.upper_data_oe == $past(rd_active)) &&
          (data_pins.shared_low_data_oe == $past(rd_active));
  endproperty
  a_oe: assert property (p_oe)
    else $error("data drivers not tied to select and read");

  property p_busy_level;
    @(posedge clk) disable iff (!nrst)
      ($fell(busy_n) |-> $past(start)) and
      ($rose(busy_n) |-> $past(push_valid));
  endproperty
  a_busy_level: assert property (p_busy_level)
    else $error("busy moved without a start or a finished word");

  property p_full_word;
    @(posedge clk) disable iff (!nrst)
      rd_active && !pin_s.upper_byte_select && $stable(state_reg.latch)
      |=> {data_pins.upper_data_outputs,
           data_pins.shared_low_data_outputs} == $past(state_reg.latch);
  endproperty
  a_full_word: assert property (p_full_word)
    else $error("full word read out of order");

  property p_byte_read;
    @(posedge clk) disable iff (!nrst)
      rd_active && pin_s.upper_byte_select
      |=> data_pins.upper_data_outputs[3:0] == 4'h0 &&
          data_pins.shared_low_data_outputs ==
            data_pins.upper_data_outputs[7:4];
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("upper byte layout wrong");

  property p_sar_clear;
    @(posedge clk) disable iff (!nrst)
      start |=> trial_code == 12'h800 && state_reg.step_cnt == '0;
  endproperty
  a_sar_clear: assert property (p_sar_clear)
    else $error("sar not cleared at start");

  property p_no_restart;
    @(posedge clk) disable iff (!nrst)
      (state_reg.st == sar_adc_pkg::ST_STEP) && !step_end
      |=> state_reg.st == sar_adc_pkg::ST_STEP &&
          $stable(state_reg.bit_idx);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted mid step");

  property p_bit_decide;
    @(posedge clk) disable iff (!nrst)
      step_end && !pin_s.cmp_hi
      |=> (trial_code & bit_mask($past(state_reg.bit_idx))) == '0;
  endproperty
  a_bit_decide: assert property (p_bit_decide)
    else $error("rejected trial bit kept");

  property p_latch_load;
    @(posedge clk) disable iff (!nrst)
      buf_out_valid && buf_out_ready
      |=> state_reg.latch == $past(buf_out_data);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch missed the finished word");

  // the step counter only runs inside a conversion
  property p_step_idle;
    @(posedge clk) disable iff (!nrst)
      (state_reg.st != sar_adc_pkg::ST_STEP) |-> state_reg.step_cnt == '0;
  endproperty
  a_step_idle: assert property (p_step_idle)
    else $error("step clock running outside a conversion");

  property p_old_word;
    @(posedge clk) disable iff (!nrst)
      start |=> {data_pins.upper_data_outputs,
                 data_pins.shared_low_data_outputs} == $past(state_reg.latch);
  endproperty
  a_old_word: assert property (p_old_word)
    else $error("start read did not show the previous word");

endmodule : sar_adc_control

// ### rtl/sar_adc_defines.svh
// timing counts, widths and codes of the sar converter control
// assumes a 100 MHz clk; included by bare name after the package
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define CONV_TIME_NS    6000
`define SAMPLE_TIME_NS  1140
`define CONV_STEPS      13
`define STEP_CYC        ((`CONV_TIME_NS / `CLK_PERIOD_NS) / `CONV_STEPS)
`define SAMPLE_CYC      ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// result layout
// ****************************************************************
`define RES_W           12
`define MSB_IDX         4'hb
`define SAR_START       12'h800
`define SAR_RESET       12'h000
`define LATCH_RESET     12'h000
// synchroniser reset: selects and strobe idle high, byte select low
`define PIN_IDLE        4'hc
`define STEP_CNT_W      6
`define FULL_SCALE_CODES 4096

`endif

// ### rtl/sar_adc_pkg.sv
// types shared by the sar converter control
// no dependencies
package sar_adc_pkg;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STEP,
    ST_PUSH
  } conv_state_t;

  // synchronised host pins and comparator
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic upper_byte_select;
    logic cmp_hi;
  } pins_t;

  // three-state data pins as value plus enable
  typedef struct packed {
    logic [7:0] upper_data_outputs;
    logic       upper_data_oe;
    logic [3:0] shared_low_data_outputs;
    logic       shared_low_data_oe;
  } data_pins_t;

endpackage : sar_adc_pkg

// ### testbench/analog_front_model.sv
// behavioural sample-and-hold, dac and comparator at the far side
// assumes trial_code and sample_track come from the converter control
`timescale 1ns/1ns
module analog_front_model (
  input  wire logic        clk,
  input  wire logic [11:0] ain_code,
  input  wire logic        sample_track,
  input  wire logic [11:0] trial_code,
  output logic             cmp_in
);
  // ****************************************************************
  // hold and compare
  // ****************************************************************
  logic [11:0] held_reg;

  initial held_reg = 12'h000;

  // the held code freezes while converting, so input moves are ignored
  always @(posedge clk) begin
    if (sample_track) begin
      held_reg <= ain_code;
    end
  end

  // natural binary: a trial bit is kept when input is at or above it
  assign cmp_in = (held_reg >= trial_code);
endmodule : analog_front_model

// ### testbench/tb_sar_adc_control.sv
// self-checking bench of the sar converter control
// assumes the analog_front_model closes the comparator loop
`timescale 1ns/1ns
`define CMP(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, \
  exp); end end
module tb_sar_adc_control;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                    clk;
  logic                    nrst;
  logic                    cs_n;
  logic                    rd_n;
  logic                    upper_byte_select;
  logic [11:0]             ain_code;
  logic                    cmp_in;
  logic                    busy_n;
  logic [11:0]             trial_code;
  logic                    sample_track;
  sar_adc_pkg::data_pins_t data_pins;
  logic [11:0]             last_word;
  logic [11:0]             word;
  int                      fail_count;
  int                      comparisons;
  int                      low_cnt = 0;
  int                      low_base;
  int                      wait_n;

  assign word = {data_pins.upper_data_outputs,
                 data_pins.shared_low_data_outputs};

  sar_adc_control dut_u (
    .clk               (clk),
    .nrst              (nrst),
    .cs_n              (cs_n),
    .rd_n              (rd_n),
    .upper_byte_select (upper_byte_select),
    .cmp_in            (cmp_in),
    .busy_n            (busy_n),
    .trial_code        (trial_code),
    .sample_track      (sample_track),
    .data_pins         (data_pins)
  );

  analog_front_model model_u (
    .clk          (clk),
    .ain_code     (ain_code),
    .sample_track (sample_track),
    .trial_code   (trial_code),
    .cmp_in       (cmp_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts every cycle busy_n is low; tests take differences of it
  always @(posedge clk) begin
    if (busy_n === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task final_report;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task wait_busy(input logic lvl);
    wait_n = 0;
    while (busy_n !== lvl) begin
      @(negedge clk);
      wait_n++;
      if (wait_n > 2000) begin
        fail_count++;
        $display("MISMATCH t=%0t busy got=%h exp=%h", $time, busy_n, lvl);
        final_report();
      end
    end
  endtask : wait_busy

  // select and byte select settle a cycle before the strobe falls
  task read_start(input logic ubs, input int hold);
    @(negedge clk);
    cs_n = 1'b0;
    upper_byte_select = ubs;
    @(negedge clk);
    rd_n = 1'b0;
    repeat (hold) @(negedge clk);
  endtask : read_start

  task release_bus;
    @(negedge clk);
    rd_n = 1'b1;
    cs_n = 1'b1;
    upper_byte_select = 1'b0;
    repeat (4) @(negedge clk);
  endtask : release_bus

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task test_reset;
    `CMP(busy_n, 1'b1)
    `CMP(data_pins.upper_data_oe, 1'b0)
    `CMP(data_pins.shared_low_data_oe, 1'b0)
    `CMP(trial_code, 12'h000)
    $display("test reset done");
  endtask : test_reset

  task test_cs_high;
    @(negedge clk);
    upper_byte_select = 1'b0;
    rd_n = 1'b0;
    repeat (10) @(negedge clk);
    `CMP(busy_n, 1'b1)
    `CMP(data_pins.upper_data_oe, 1'b0)
    release_bus();
    $display("test cs high done");
  endtask : test_cs_high

  task test_upper(input logic [11:0] exp);
    read_start(1'b1, 8);
    `CMP(busy_n, 1'b1)
    `CMP(data_pins.upper_data_oe, 1'b1)
    `CMP(data_pins.shared_low_data_outputs, exp[11:8])
    `CMP(data_pins.upper_data_outputs, {exp[11:8], 4'h0})
    release_bus();
    `CMP(data_pins.shared_low_data_oe, 1'b0)
    `CMP(busy_n, 1'b1)
    $display("test upper byte done");
  endtask : test_upper

  // short start read, then a second start inside the conversion
  task test_convert(input logic [11:0] val);
    ain_code = val;
    low_base = low_cnt;
    read_start(1'b0, 8);
    `CMP(busy_n, 1'b0)
    `CMP(sample_track, 1'b0)
    `CMP(data_pins.upper_data_oe, 1'b1)
    `CMP(trial_code, 12'h800)
    `CMP(word, last_word)
    release_bus();
    repeat (100) @(negedge clk);
    read_start(1'b0, 8);
    `CMP(busy_n, 1'b0)
    release_bus();
    wait_busy(1'b1);
    `CMP(low_cnt - low_base, 553)
    `CMP(sample_track, 1'b1)
    last_word = val;
    repeat (114) @(negedge clk);
    $display("test convert %h done", val);
  endtask : test_convert

  task test_long_read(input logic [11:0] val);
    ain_code = val;
    read_start(1'b0, 4);
    wait_busy(1'b0);
    wait_busy(1'b1);
    repeat (4) @(negedge clk);
    `CMP(word, val)
    release_bus();
    last_word = val;
    repeat (114) @(negedge clk);
    $display("test long read done");
  endtask : test_long_read

  // reset in the middle of a conversion drops it and clears the latch
  task test_mid_reset;
    ain_code = 12'h5a5;
    read_start(1'b0, 8);
    release_bus();
    `CMP(busy_n, 1'b0)
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    `CMP(busy_n, 1'b1)
    `CMP(sample_track, 1'b1)
    `CMP(trial_code, 12'h000)
    last_word = 12'h000;
    repeat (114) @(negedge clk);
    $display("test mid reset done");
  endtask : test_mid_reset

  // upper byte read held across the end of a conversion keeps the
  // old byte; the buffered word reaches the next read
  task test_byte_pair(input logic [11:0] val);
    ain_code = val;
    read_start(1'b0, 4);
    release_bus();
    read_start(1'b1, 4);
    `CMP(busy_n, 1'b0)
    wait_busy(1'b1);
    repeat (4) @(negedge clk);
    `CMP(data_pins.shared_low_data_outputs, last_word[11:8])
    release_bus();
    read_start(1'b1, 4);
    `CMP(data_pins.upper_data_outputs, {val[11:8], 4'h0})
    `CMP(data_pins.shared_low_data_outputs, val[11:8])
    release_bus();
    last_word = val;
    repeat (114) @(negedge clk);
    $display("test byte pair done");
  endtask : test_byte_pair

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    fail_count = 0;
    comparisons = 0;
    last_word = 12'h000;
    nrst = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    upper_byte_select = 1'b0;
    ain_code = 12'h000;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    test_reset();
    test_cs_high();
    test_upper(12'h000);
    test_convert(12'hfff);
    test_upper(12'hfff);
    test_convert(12'h000);
    test_convert(12'ha5c);
    test_upper(12'ha5c);
    test_convert(12'h3c1);
    test_long_read(12'h6b7);
    test_convert(12'h001);
    test_upper(12'h001);
    test_mid_reset();
    test_convert(12'h5a5);
    test_byte_pair(12'hc3e);
    final_report();
  end
endmodule : tb_sar_adc_control
